/* File: css_clock_switcher.sv */
// Clock source switcher: registers, crystal settling counter and selectors.
// Assumes a 25 MHz clock, crystal edges presented as a synchronous input,
// and on-chip oscillators reporting running by synchronous levels.
//
// What this block does
// R1 - Software sets gain bit above 10 MHz crystal, clears it otherwise.
// R2 - Pin mode alone runs crystal; with external bit accepts external clock.
// R3 - Three-bit settle select sets crystal wait; code 010 about 102 us.
// R4 - Clearing crystal stop starts crystal; external clock applied first.
// R5 - Read-only settle flags set progressively; 11100000 means 102 us.
// R6 - Clearing cpu source select moves cpu clock to main clock.
// R7 - Cpu source status reads 0 on main clock, 1 on subsystem.
// R8 - Software stops slow oscillator only after status shows main clock.
// R9 - Slow oscillator kept running while wake-up timer clock bit is 1.
// R10 - Main source select must not change while cpu runs on subsystem.
// R11 - Clearing fast stop starts fast oscillator; software times 65 us.
// R12 - Setting middle enable starts middle oscillator; software times 4 us.
// R13 - Clearing main source select moves main clock to on-chip oscillator.
// R14 - Main source status reads 1 on crystal, 0 on on-chip oscillator.
// R15 - Software stops crystal after main status reads 0; device stops it.
// R16 - On-chip select 0 is fast, 1 middle; status reports which.
// R17 - Switches take effect only with new source running, glitch free; the cpu return to main clock is not gated on main running.
module css_clock_switcher #(
  parameter int SETTLE_WIDTH = css_pkg::SETTLE_W
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       crystal_edge,
  input  wire logic       fast_running,
  input  wire logic       middle_running,
  input  wire logic       slow_running,
  output logic            crystal_amp_en,
  output logic            crystal_gain_high,
  output logic            ext_clock_accept,
  output logic            fast_osc_en,
  output logic            middle_osc_en,
  output logic            slow_osc_en,
  output logic      [1:0] cpu_source
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (SETTLE_WIDTH < css_pkg::SETTLE_W) begin : g_bad_width
    $error("settle counter too narrow for the 2^18 flag");
  end

  // ****************************************
  // Software registers
  // ****************************************
  logic [7:0]                      mode_q;
  logic [css_pkg::SETTLE_CODE_W-1:0] settle_sel_q;
  logic [7:0]                      run_q;
  logic                            cpu_sel_q;
  logic                            main_sel_q;
  logic                            onchip_sel_q;
  logic                            slow_sel_q;
  logic [7:0]                      supply_q;
  logic [7:0]                      rdata_q;
  logic                            cpu_status_q;

  // Address decode
  wire wr_mode   = reg_write && reg_addr == css_pkg::OFS_MODE_CTRL;
  wire wr_settle = reg_write && reg_addr == css_pkg::OFS_SETTLE_SEL;
  wire wr_run    = reg_write && reg_addr == css_pkg::OFS_RUN_CTRL;
  wire wr_sys    = reg_write && reg_addr == css_pkg::OFS_SYS_SEL;
  wire wr_sub    = reg_write && reg_addr == css_pkg::OFS_SUB_SEL;
  wire wr_supply = reg_write && reg_addr == css_pkg::OFS_SUPPLY;

  wire pin_mode   = mode_q[css_pkg::BIT_PIN_MODE];
  wire ext_select = mode_q[css_pkg::BIT_EXT_INPUT];
  wire xtal_stop  = run_q[css_pkg::BIT_CRYSTAL_STOP];

  // Register writes; the pin mode bit can be set and cleared by any mode write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q       <= css_pkg::RST_MODE_CTRL;
      settle_sel_q <= css_pkg::RST_SETTLE_SEL;
      run_q        <= css_pkg::RST_RUN_CTRL;
      cpu_sel_q    <= 1'b0;
      main_sel_q   <= 1'b0;
      onchip_sel_q <= 1'b0;
      slow_sel_q   <= 1'b0;
      supply_q     <= css_pkg::RST_SUPPLY;
    end else begin
      if (wr_mode) begin
        mode_q <= reg_wdata & 8'hC1;
      end
      if (wr_settle) begin
        settle_sel_q <= reg_wdata[css_pkg::SETTLE_CODE_W-1:0]; // R3
      end
      if (wr_run) begin
        run_q <= (reg_wdata & 8'h83) | 8'h40;                  // R4 R11 R12 R15
      end
      if (wr_sys) begin
        cpu_sel_q    <= reg_wdata[css_pkg::BIT_CPU_SEL];       // R6
        onchip_sel_q <= reg_wdata[css_pkg::BIT_ONCHIP_SEL];    // R16
        // Held while the cpu runs on subsystem clock
        if (!cpu_status_q) begin
          main_sel_q <= reg_wdata[css_pkg::BIT_MAIN_SEL];      // R10 R13
        end
      end
      if (wr_sub) begin
        slow_sel_q <= reg_wdata[css_pkg::BIT_SLOW_SEL];
      end
      if (wr_supply) begin
        supply_q <= reg_wdata & 8'h10;
      end
    end
  end

  // ****************************************
  // Oscillator enables
  // ****************************************
  logic amp_q;
  logic gain_q;
  logic ext_q;
  logic fast_q;
  logic middle_q;
  logic slow_q;

  // Crystal runs in pin mode unless stopped; external bit skips amplifier
  wire amp_d  = pin_mode && !ext_select && !xtal_stop; // R2 R4 R15
  wire ext_d  = pin_mode && ext_select && !xtal_stop;  // R2
  // Slow oscillator forced on for the wake-up timer
  wire slow_d = slow_sel_q || supply_q[css_pkg::BIT_WAKE_CLK]
                || cpu_status_q;                       // R9

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      amp_q    <= 1'b0;
      gain_q   <= 1'b0;
      ext_q    <= 1'b0;
      fast_q   <= 1'b1;
      middle_q <= 1'b0;
      slow_q   <= 1'b1;
    end else begin
      amp_q    <= amp_d;
      gain_q   <= mode_q[css_pkg::BIT_GAIN_HIGH];        // R1
      ext_q    <= ext_d;
      fast_q   <= !run_q[css_pkg::BIT_FAST_STOP];        // R11
      middle_q <= run_q[css_pkg::BIT_MIDDLE_EN];         // R12
      slow_q   <= slow_d;
    end
  end

  // ****************************************
  // Crystal settling counter
  // ****************************************
  // Counts crystal edges; restarts whenever the crystal is stopped.
  logic [SETTLE_WIDTH-1:0] settle_cnt_q;
  logic [7:0]              flags_q;
  wire [7:0] flags_d = {settle_cnt_q[8], settle_cnt_q[9],
                        settle_cnt_q[10], settle_cnt_q[11],
                        settle_cnt_q[13], settle_cnt_q[15],
                        settle_cnt_q[17], settle_cnt_q[18]};

  // Flags latch once set so the pattern only grows
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_q <= '0;
      flags_q      <= 8'h00;
    end else if (!amp_q) begin
      settle_cnt_q <= '0;
      flags_q      <= 8'h00;
    end else begin
      if (crystal_edge && !flags_q[0]) begin
        settle_cnt_q <= settle_cnt_q + 1'b1;
      end
      flags_q <= flags_q | flags_d;                      // R5
    end
  end

  // Selected wait reached: code n needs flag 7-n; 010 maps to bit 5
  wire [2:0] sel_idx = 3'h7 - settle_sel_q;
  wire settle_done = flags_q[sel_idx];                   // R3
  wire crystal_ok  = ext_q || (amp_q && settle_done);    // R5 R17

  // ****************************************
  // Clock selectors
  // ****************************************
  css_sel_if onchip_if ();
  css_sel_if main_if ();
  css_sel_if cpu_if ();

  wire onchip_running = onchip_if.done ? middle_running : fast_running;

  assign onchip_if.req    = onchip_sel_q;                // R16
  assign onchip_if.new_ok = onchip_sel_q ? middle_running : fast_running;
  assign onchip_if.old_ok = 1'b1;
  assign main_if.req      = main_sel_q;                  // R13
  assign main_if.new_ok   = main_sel_q ? crystal_ok : onchip_running;
  assign main_if.old_ok   = 1'b1;
  assign cpu_if.req       = cpu_sel_q;                   // R6
  assign cpu_if.new_ok    = cpu_sel_q ? slow_running : 1'b1;
  assign cpu_if.old_ok    = 1'b1;

  css_glitchfree_mux u_onchip (
    .clock   (clock),
    .reset_n (reset_n),
    .sel     (onchip_if)
  );
  css_glitchfree_mux u_main (
    .clock   (clock),
    .reset_n (reset_n),
    .sel     (main_if)
  );
  css_glitchfree_mux u_cpu (
    .clock   (clock),
    .reset_n (reset_n),
    .sel     (cpu_if)
  );

  // ****************************************
  // Status and read data
  // ****************************************
  logic [1:0] src_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu_status_q <= 1'b0;
    end else begin
      cpu_status_q <= cpu_if.done;                       // R7
    end
  end

  wire [7:0] sys_rd = {cpu_status_q, cpu_sel_q, main_if.done, main_sel_q,
                       2'b00, onchip_if.done, onchip_sel_q}; // R14 R16
  wire [7:0] rd_mux =
    (reg_addr == css_pkg::OFS_MODE_CTRL)   ? mode_q :
    (reg_addr == css_pkg::OFS_SETTLE_SEL)  ? {5'h00, settle_sel_q} :
    (reg_addr == css_pkg::OFS_RUN_CTRL)    ? run_q :
    (reg_addr == css_pkg::OFS_SETTLE_STAT) ? flags_q :
    (reg_addr == css_pkg::OFS_SYS_SEL)     ? sys_rd :
    (reg_addr == css_pkg::OFS_SUB_SEL)     ? {7'h00, slow_sel_q} :
    (reg_addr == css_pkg::OFS_SUPPLY)      ? supply_q : 8'h00;

  wire [1:0] src_d = cpu_if.done ? 2'(css_pkg::CSS_SRC_SLOW) :
                     main_if.done ? 2'(css_pkg::CSS_SRC_CRYSTAL) :
                     onchip_if.done ? 2'(css_pkg::CSS_SRC_MIDDLE) :
                     2'(css_pkg::CSS_SRC_FAST);

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
      src_q   <= 2'h0;
    end else begin
      rdata_q <= reg_read ? rd_mux : 8'h00;
      src_q   <= src_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign crystal_amp_en    = amp_q;
  assign crystal_gain_high = gain_q;
  assign ext_clock_accept  = ext_q;
  assign fast_osc_en       = fast_q;
  assign middle_osc_en     = middle_q;
  assign slow_osc_en       = slow_q;
  assign cpu_source        = src_q;

endmodule : css_clock_switcher

/* File: css_pkg.sv */
// Constants and types shared by the clock source switcher files.
// Assumes a single 25 MHz system clock and byte-wide software registers.
package css_pkg;

  // ****************************************
  // Register offsets (byte-wide registers)
  // ****************************************
  localparam logic [2:0] OFS_MODE_CTRL = 3'h0;  // oscillator_mode_control
  localparam logic [2:0] OFS_SETTLE_SEL = 3'h1; // stabilization_time_select
  localparam logic [2:0] OFS_RUN_CTRL = 3'h2;   // oscillator_run_control
  localparam logic [2:0] OFS_SETTLE_STAT = 3'h3; // stabilization_counter_status
  localparam logic [2:0] OFS_SYS_SEL = 3'h4;    // system_clock_select
  localparam logic [2:0] OFS_SUB_SEL = 3'h5;    // subsystem_source_select
  localparam logic [2:0] OFS_SUPPLY = 3'h6;     // subsystem_supply_mode

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_EXT_INPUT = 7;    // external_input_select
  localparam int BIT_PIN_MODE = 6;     // high_speed_pin_mode
  localparam int BIT_GAIN_HIGH = 0;    // crystal_gain_high
  localparam int BIT_CRYSTAL_STOP = 7; // crystal_stop
  localparam int BIT_MIDDLE_EN = 1;    // middle_osc_enable
  localparam int BIT_FAST_STOP = 0;    // fast_osc_stop
  localparam int BIT_CPU_STAT = 7;     // cpu_source_status
  localparam int BIT_CPU_SEL = 6;      // cpu_source_select
  localparam int BIT_MAIN_STAT = 5;    // main_source_status
  localparam int BIT_MAIN_SEL = 4;     // main_source_select
  localparam int BIT_ONCHIP_STAT = 1;  // onchip_osc_status
  localparam int BIT_ONCHIP_SEL = 0;   // onchip_osc_select
  localparam int BIT_SLOW_SEL = 0;     // slow_osc_select
  localparam int BIT_WAKE_CLK = 4;     // wakeup_timer_clock_select

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [2:0] RST_SETTLE_SEL = 3'h7;
  localparam logic [7:0] RST_RUN_CTRL = 8'hC0;  // crystal stopped
  localparam logic [7:0] RST_SYS_SEL = 8'h00;
  localparam logic [7:0] RST_SUB_SEL = 8'h00;
  localparam logic [7:0] RST_SUPPLY = 8'h00;

  // ****************************************
  // Settling counter: flags set at 2^k crystal edges
  // ****************************************
  localparam int SETTLE_W = 19;
  localparam int SETTLE_CODE_W = 3;
  localparam logic [SETTLE_CODE_W-1:0] SETTLE_CODE_102US = 3'h2; // 2^10
  localparam int SETTLE_FLAGS = 8;
  localparam int SYNC_STAGES = 2;

  // Source status encodings
  typedef enum logic [1:0] {
    CSS_SRC_FAST,
    CSS_SRC_MIDDLE,
    CSS_SRC_CRYSTAL,
    CSS_SRC_SLOW
  } css_src_t;

endpackage : css_pkg

/* File: css_sel_if.sv */
// Interface carrying one clock-select handshake between switcher modules.
// Assumes a single clock domain for both ends.
interface css_sel_if;
  logic req;    // Requested source is 1, old source is 0
  logic done;   // Changeover has taken effect
  logic new_ok; // New source is running
  logic old_ok; // Old source is running
  modport ctrl (output req, output new_ok, output old_ok, input done);
  modport mux  (input req, input new_ok, input old_ok, output done);
endinterface : css_sel_if

/* File: css_glitchfree_mux.sv */
// Glitch-free changeover handshake for one two-way clock selector.
// Assumes the running indications are synchronous to clock.
module css_glitchfree_mux (
  input  wire logic clock,
  input  wire logic reset_n,
  css_sel_if.mux    sel
);

  // ****************************************
  // Changeover sequencing
  // ****************************************
  // Old side is gated off first, then new side gated on once running,
  // so the output never sees a partial pulse.
  typedef enum {CSS_HOLD, CSS_GAP} css_mux_state_t;
  css_mux_state_t state_q;
  logic           cur_q;
  logic           done_q;
  wire            want_change = sel.req != cur_q;

  // Switch only when the new source is running
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CSS_HOLD;
      cur_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      unique case (state_q)
        CSS_HOLD: begin
          if (want_change && sel.new_ok) begin  // R17
            state_q <= CSS_GAP;
          end
        end
        CSS_GAP: begin
          cur_q   <= sel.req;                   // R17
          state_q <= CSS_HOLD;
        end
      endcase
      done_q <= (state_q == CSS_HOLD) ? cur_q : done_q;
    end
  end

  assign sel.done = done_q;

endmodule : css_glitchfree_mux

/* File: css_clock_switcher_properties.sv */
// Port-level checker for the clock source switcher.
// Assumes the css_pkg register map; bound onto every switcher instance.
module css_clock_switcher_properties #(
  parameter int SETTLE_WIDTH = css_pkg::SETTLE_W
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       crystal_edge,
  input wire logic       fast_running,
  input wire logic       middle_running,
  input wire logic       slow_running,
  input wire logic       crystal_amp_en,
  input wire logic       crystal_gain_high,
  input wire logic       ext_clock_accept,
  input wire logic       fast_osc_en,
  input wire logic       middle_osc_en,
  input wire logic       slow_osc_en,
  input wire logic [1:0] cpu_source
);
  // ****************
  // Bus shadows
  // ****************
  logic      pin_q;
  logic      ext_q;
  logic      wake_q;
  wire logic wr_run = reg_write && reg_addr == css_pkg::OFS_RUN_CTRL;
  // Mode and wake bits as written; status reads are not trusted here
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_q  <= 1'b0;
      ext_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      if (reg_write && reg_addr == css_pkg::OFS_MODE_CTRL) begin
        pin_q <= reg_wdata[css_pkg::BIT_PIN_MODE];
        ext_q <= reg_wdata[css_pkg::BIT_EXT_INPUT];
      end
      if (reg_write && reg_addr == css_pkg::OFS_SUPPLY) begin
        wake_q <= reg_wdata[css_pkg::BIT_WAKE_CLK];
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  property p_unmapped;
    reg_read && reg_addr == 3'h7 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped offset read not zero");
  property p_crystal_start;
    wr_run && !reg_wdata[7] && pin_q && !ext_q |-> ##2 crystal_amp_en;
  endproperty
  a_crystal_start: assert property (p_crystal_start)
    else $error("crystal amplifier not started");
  property p_ext_start;
    wr_run && !reg_wdata[7] && pin_q && ext_q |-> ##2 ext_clock_accept;
  endproperty
  a_ext_start: assert property (p_ext_start)
    else $error("external clock not accepted");
  property p_crystal_stop;
    wr_run && reg_wdata[7] && cpu_source != 2'h2
      |-> ##2 !crystal_amp_en && !ext_clock_accept;
  endproperty
  a_crystal_stop: assert property (p_crystal_stop)
    else $error("crystal not stopped");
  property p_fast_run;
    wr_run && cpu_source != 2'h0
      |-> ##2 fast_osc_en != $past(reg_wdata[css_pkg::BIT_FAST_STOP], 2);
  endproperty
  a_fast_run: assert property (p_fast_run)
    else $error("fast oscillator enable wrong");
  property p_middle_run;
    wr_run && cpu_source != 2'h1
      |-> ##2 middle_osc_en == $past(reg_wdata[css_pkg::BIT_MIDDLE_EN], 2);
  endproperty
  a_middle_run: assert property (p_middle_run)
    else $error("middle oscillator enable wrong");
  property p_wake_hold;
    wake_q && $past(wake_q) |-> slow_osc_en;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("slow oscillator stopped under wake bit");
  property p_slow_hold;
    cpu_source == 2'h3 |-> slow_osc_en;
  endproperty
  a_slow_hold: assert property (p_slow_hold)
    else $error("slow oscillator stopped while in use");
  property p_switch_ready;
    $changed(cpu_source) |-> cpu_source == 2'h2
      || (cpu_source == 2'h0 && fast_running)
      || (cpu_source == 2'h1 && middle_running)
      || (cpu_source == 2'h3 && slow_running);
  endproperty
  a_switch_ready: assert property (p_switch_ready)
    else $error("switched to a source not running");
endmodule // css_clock_switcher_properties

bind css_clock_switcher css_clock_switcher_properties #(
  .SETTLE_WIDTH(SETTLE_WIDTH)
) u_props (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .crystal_edge(crystal_edge),
  .fast_running(fast_running), .middle_running(middle_running),
  .slow_running(slow_running), .crystal_amp_en(crystal_amp_en),
  .crystal_gain_high(crystal_gain_high),
  .ext_clock_accept(ext_clock_accept), .fast_osc_en(fast_osc_en),
  .middle_osc_en(middle_osc_en), .slow_osc_en(slow_osc_en),
  .cpu_source(cpu_source)
);

/* File: css_osc_model.sv */
// Behavioural crystal, external clock source and on-chip oscillators.
// Assumes the switcher enables are levels on the same clock.
module css_osc_model (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic ext_on,
  input  wire logic crystal_amp_en,
  input  wire logic fast_osc_en,
  input  wire logic middle_osc_en,
  input  wire logic slow_osc_en,
  output logic      crystal_edge,
  output logic      fast_running,
  output logic      middle_running,
  output logic      slow_running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_q;
  logic [3:0] xtal_q;
  logic [3:0] fast_q;
  logic [3:0] mid_q;
  logic [3:0] slow_q;
  // Start-up delays; a stopped oscillator reports idle one clock after its enable falls
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 3'h0;
      xtal_q  <= 4'h0;
      fast_q  <= 4'h0;
      mid_q   <= 4'h0;
      slow_q  <= 4'h0;
    end else begin
      phase_q <= (phase_q == 3'h4) ? 3'h0 : phase_q + 3'h1;
      xtal_q  <= crystal_amp_en ? xtal_q + 4'(xtal_q != 4'hC) : 4'h0;
      fast_q  <= fast_osc_en ? fast_q + 4'(fast_q != 4'h8) : 4'h0;
      mid_q   <= middle_osc_en ? mid_q + 4'(mid_q != 4'h3) : 4'h0;
      slow_q  <= slow_osc_en ? slow_q + 4'(slow_q != 4'h4) : 4'h0;
    end
  end
  // 20 MHz source: four edges in five clocks, silent when stopped
  assign crystal_edge   = (xtal_q == 4'hC || ext_on) && phase_q != 3'h0;
  assign fast_running   = fast_q == 4'h8;
  assign middle_running = mid_q == 4'h3;
  assign slow_running   = slow_q == 4'h4;
endmodule // css_osc_model

/* File: css_clock_switcher_bench.sv */
// Self-checking bench for the clock source switcher.
// Assumes css_osc_model at the far side and the bound port checker.
module css_clock_switcher_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    failures++; $display("wrong value at %0t: %h not %h", $time, a, b); \
  end end
  typedef struct packed {logic [7:0] exp; logic [7:0] mask;} css_note_t;
  logic       clock = 1'b0;
  logic       reset_n = 1'b0;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       rd_seen = 1'b0;
  logic       ext_on = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, rd, v;
  logic       xe, fr, mr, sr, amp, gain, ext, fe, me, se;
  logic [1:0] cpu;
  int         failures = 0;
  int         checks_done = 0;
  int         seed = 32'h3cfe692d;
  css_note_t  notes[$];
  css_note_t  note;
  logic [7:0] rst_v [8] = '{css_pkg::RST_MODE_CTRL,
    {5'h00, css_pkg::RST_SETTLE_SEL}, css_pkg::RST_RUN_CTRL, 8'h00,
    css_pkg::RST_SYS_SEL, css_pkg::RST_SUB_SEL, css_pkg::RST_SUPPLY, 8'h00};
  initial forever #20 clock = ~clock;
  css_clock_switcher DUT (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .crystal_edge(xe), .fast_running(fr),
    .middle_running(mr), .slow_running(sr), .crystal_amp_en(amp),
    .crystal_gain_high(gain), .ext_clock_accept(ext), .fast_osc_en(fe),
    .middle_osc_en(me), .slow_osc_en(se), .cpu_source(cpu));
  css_osc_model u_osc (
    .clock(clock), .reset_n(reset_n), .ext_on(ext_on),
    .crystal_amp_en(amp), .fast_osc_en(fe), .middle_osc_en(me),
    .slow_osc_en(se), .crystal_edge(xe), .fast_running(fr),
    .middle_running(mr), .slow_running(sr));
  // ****************
  // Bus tasks and read-data monitor
  // ****************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Notes the expectation; the monitor compares when data stand
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, m);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    notes.push_back('{e, m});
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    rd = reg_rdata;
  endtask
  // Bounded status poll; running out of tries ends the run
  task automatic poll(input logic [2:0] a, input int b, input logic w);
    int n;
    n = 0;
    rd[b] = ~w;
    while (rd[b] !== w && n < 2000) begin
      rd_chk(a, 8'h00, 8'h00);
      n++;
    end
    if (rd[b] !== w) begin
      $display("wrong value at %0t: poll ran out", $time);
      failures++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) begin
      note = notes.pop_front();
      `CHK(reg_rdata & note.mask, note.exp)
    end
    rd_seen <= reg_read;
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(3'(i), rst_v[i], 8'hFF);
    v = 8'($random(seed));
    wr(css_pkg::OFS_SETTLE_SEL, v);
    wr(3'h7, v);
    rd_chk(css_pkg::OFS_SETTLE_SEL, {5'h00, v[2:0]}, 8'h07);
    rd_chk(3'h7, 8'h00, 8'hFF);
    // Onto the slow oscillator, wake-up timer keeping it alive
    wr(css_pkg::OFS_SUPPLY, 8'h10);
    wr(css_pkg::OFS_SUB_SEL, 8'h01);
    wr(css_pkg::OFS_SYS_SEL, 8'h40);
    poll(css_pkg::OFS_SYS_SEL, 7, 1'b1);
    `CHK(cpu, 2'h3)
    // Slow to crystal; main select refused while on subsystem
    wr(css_pkg::OFS_MODE_CTRL, 8'h41);
    wr(css_pkg::OFS_SETTLE_SEL, {5'h00, css_pkg::SETTLE_CODE_102US});
    wr(css_pkg::OFS_RUN_CTRL, 8'h40);
    repeat (2) @(posedge clock);
    `CHK({amp, gain, ext}, 3'b110)
    poll(css_pkg::OFS_SETTLE_STAT, 5, 1'b1);
    `CHK(rd, 8'hE0)
    wr(css_pkg::OFS_SYS_SEL, 8'h10);
    poll(css_pkg::OFS_SYS_SEL, 7, 1'b0);
    rd_chk(css_pkg::OFS_SYS_SEL, 8'h00, 8'h30);
    `CHK(cpu, 2'h0)
    wr(css_pkg::OFS_SYS_SEL, 8'h10);
    poll(css_pkg::OFS_SYS_SEL, 5, 1'b1);
    `CHK(cpu, 2'h2)
    wr(css_pkg::OFS_SUB_SEL, 8'h00);
    repeat (3) @(posedge clock);
    `CHK(se, 1'b1)
    wr(css_pkg::OFS_SUPPLY, 8'h00);
    repeat (3) @(posedge clock);
    `CHK(se, 1'b0)
    // Crystal to middle oscillator, then stop crystal and fast
    wr(css_pkg::OFS_RUN_CTRL, 8'h42);
    repeat (100) @(posedge clock);
    `CHK(me, 1'b1)
    wr(css_pkg::OFS_SYS_SEL, 8'h01);
    poll(css_pkg::OFS_SYS_SEL, 5, 1'b0);
    rd_chk(css_pkg::OFS_SYS_SEL, 8'h03, 8'h03);
    `CHK(cpu, 2'h1)
    wr(css_pkg::OFS_RUN_CTRL, 8'hC3);
    repeat (2) @(posedge clock);
    `CHK({amp, fe}, 2'b00)
    // External clock applied first, then back to fast oscillator
    ext_on <= 1'b1;
    wr(css_pkg::OFS_MODE_CTRL, 8'hC0);
    wr(css_pkg::OFS_RUN_CTRL, 8'h42);
    repeat (1625) @(posedge clock);
    `CHK({ext, fe}, 2'b11)
    wr(css_pkg::OFS_SYS_SEL, 8'h11);
    poll(css_pkg::OFS_SYS_SEL, 5, 1'b1);
    `CHK(cpu, 2'h2)
    wr(css_pkg::OFS_SYS_SEL, 8'h00);
    poll(css_pkg::OFS_SYS_SEL, 5, 1'b0);
    rd_chk(css_pkg::OFS_SYS_SEL, 8'h00, 8'h03);
    `CHK(cpu, 2'h0)
    wr(css_pkg::OFS_RUN_CTRL, 8'hC0);
    ext_on <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(ext, 1'b0)
    end_of_test();
  end
endmodule // css_clock_switcher_bench
